// ==== verilog/adc_csu_pkg.sv ====
// Purpose: Shared constants and types of the converter status unit.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Offsets are byte addresses on the APB bus.
package adc_csu_pkg;

	// System clock rate.
	localparam int unsigned CLK_HZ = 25_000_000;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_TIMING  = 8'h04;
	localparam logic [7:0] OFS_TRIGSEL = 8'h08;
	localparam logic [7:0] OFS_STAGE   = 8'h0C;
	localparam logic [7:0] OFS_COUNT   = 8'h10;
	localparam logic [7:0] OFS_TARGET  = 8'h14;
	localparam logic [7:0] OFS_UPPER   = 8'h18;
	localparam logic [7:0] OFS_LOWER   = 8'h1C;
	localparam logic [7:0] OFS_SETPT   = 8'h20;
	localparam logic [7:0] OFS_RESULT  = 8'h24;
	localparam logic [7:0] OFS_FLT_HI  = 8'h28;
	localparam logic [7:0] OFS_FLT_LO  = 8'h2C;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h30;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h34;

	// Control register bit positions.
	localparam int CTRL_ON     = 0;
	localparam int CTRL_START  = 1;
	localparam int CTRL_AUTO   = 2;
	localparam int CTRL_MODE   = 3;
	localparam int CTRL_DOUBLE = 5;
	localparam int CTRL_RCSEL  = 6;
	localparam int CTRL_W      = 7;

	// Timing and target register field positions.
	localparam int TIM_PRE    = 8;
	localparam int TGT_SHIFT  = 8;

	// Interrupt status bit positions.
	localparam int IRQ_DONE = 0;
	localparam int IRQ_THR  = 1;
	localparam int IRQ_OVF  = 2;
	localparam int IRQ_W    = 3;

	// Reset values.
	localparam logic [7:0] RST_STAGE = 8'h00;
	localparam logic [7:0] RST_BYTE  = 8'h00;

	// Stage codes reported in the stage flags register.
	localparam logic [2:0] STG_IDLE  = 3'h0;
	localparam logic [2:0] STG_PRE1  = 3'h1;
	localparam logic [2:0] STG_ACQ1  = 3'h2;
	localparam logic [2:0] STG_CONV1 = 3'h3;
	localparam logic [2:0] STG_PRE2  = 3'h5;
	localparam logic [2:0] STG_ACQ2  = 3'h6;
	localparam logic [2:0] STG_CONV2 = 3'h7;

	// Computation modes.
	typedef enum logic [1:0] {
		MODE_ACCUM,
		MODE_AVERAGE,
		MODE_BURST,
		MODE_LPF
	} comp_mode_t;

	// Computation settings.
	typedef struct packed {
		comp_mode_t  mode;
		logic [2:0]  shift;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [15:0] setpoint;
	} cmp_cfg_t;

	// Computation results.
	typedef struct packed {
		logic [15:0] filter;
		logic        ovf;
		logic        above;
		logic        below;
	} cmp_res_t;

endpackage

// ==== verilog/compute_unit.sv ====
// Purpose: Accumulator, low-pass filter and threshold compare.
// Assumes: One sample strobe per finished conversion.
// Notes:   Results and flags come straight from flip-flops.
module compute_unit
	import adc_csu_pkg::*;
#(
	parameter int ACC_W = 18
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        sample_stb,
	input  wire logic [11:0] sample,
	input  wire logic        check,
	input  wire logic        restart,
	input  wire cmp_cfg_t    cfg,
	output cmp_res_t         res,
	output logic             upd
);

	logic [ACC_W-1:0] acc_q;
	logic [15:0]      lpf_q;
	logic             fresh_q;
	logic [ACC_W:0]   sum;
	logic             carry;
	logic [16:0]      diff;
	logic [16:0]      step;
	logic [16:0]      lpf_sum;
	logic [15:0]      lpf_d;
	logic [15:0]      filt_d;
	logic [16:0]      err;
	logic             above_d;
	logic             below_d;

	// Running sum with a carry that marks a wrap of the sum.
	assign sum   = {1'b0, acc_q} + (ACC_W+1)'(sample);
	assign carry = sum[ACC_W];

	// First-order low-pass: move by the difference scaled down.
	assign diff    = {5'h00, sample} - {1'b0, lpf_q};
	assign step    = 17'($signed(diff) >>> cfg.shift);
	assign lpf_sum = {1'b0, lpf_q} + step;
	assign lpf_d   = lpf_sum[15:0];

	// Filter output per mode.
	assign filt_d = (cfg.mode == MODE_LPF) ? lpf_d :
		16'(sum[ACC_W-1:0] >> cfg.shift);

	// Deviation from the set point against both thresholds.
	assign err     = {1'b0, filt_d} - {1'b0, cfg.setpoint};
	assign above_d = $signed(err) > $signed({cfg.upper[15], cfg.upper});
	assign below_d = $signed(err) < $signed({cfg.lower[15], cfg.lower});

	// Update state and results on each sample.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q   <= '0;
			lpf_q   <= 16'h0000;
			fresh_q <= 1'b0;
			res     <= '0;
			upd     <= 1'b0;
		end else begin
			upd <= sample_stb;
			if (sample_stb) begin
				acc_q      <= restart ? '0 : sum[ACC_W-1:0];
				lpf_q      <= lpf_d;
				fresh_q    <= restart;
				res.filter <= filt_d;
				res.ovf    <= carry | (res.ovf & ~fresh_q);
				if (check) begin
					res.above <= above_d;
					res.below <= below_d;
				end
			end
		end
	end

endmodule

// ==== verilog/adc_csu.sv ====
// Purpose: Converter sequencing, status flags and filter readout.
// Assumes: APB slave with zero wait states; inputs synchronous.
// Notes:   Function
// Function
// - Setting start launches a conversion that runs on unaided.
// - Completion clears start unless a burst relaunches, sets done flag, raises enabled interrupt.
// - Enabled converter interrupt wakes device regardless of global enable.
// - Stage flags report overflow, above, below and computation done.
// - Three-bit stage code reports idle and each phase of both cycles.
// - With RC clock selected and slow system clock, stage may be invalid.
// - Repeat counter counts completed cycles, decides threshold check against target.
// - Filter output is shifted sum, or low-pass output in filter mode.
// - Sixteen-bit filter output readable only, split in two bytes.
// - Rising edge of selected trigger sets start when auto-trigger on.
module adc_csu
	import adc_csu_pkg::*;
#(
	parameter int          TRIG_N      = 4,
	parameter logic [7:0]  CONV_CYCLES = 8'h0E
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [TRIG_N-1:0] trig_in,
	input  wire logic [11:0]       conv_data,
	input  wire logic              global_irq_enable,
	output logic                   converter_on,
	output logic                   rc_clk_sel,
	output logic                   precharge_en,
	output logic                   acquire_en,
	output logic                   convert_en,
	output logic                   irq,
	output logic                   irq_vector,
	output logic                   wake
);

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE1,
		ST_ACQ1,
		ST_CONV1,
		ST_PRE2,
		ST_ACQ2,
		ST_CONV2
	} state_t;

	// Map a sequencer state to its reported stage code.
	function automatic logic [2:0] stage_code(input state_t s);
		logic [2:0] c;
		c = STG_IDLE;
		unique case (s)
			ST_IDLE:  c = STG_IDLE;
			ST_PRE1:  c = STG_PRE1;
			ST_ACQ1:  c = STG_ACQ1;
			ST_CONV1: c = STG_CONV1;
			ST_PRE2:  c = STG_PRE2;
			ST_ACQ2:  c = STG_ACQ2;
			ST_CONV2: c = STG_CONV2;
		endcase
		return c;
	endfunction

	// Register-file state.
	logic [CTRL_W-1:0] ctrl_q;
	logic [7:0]        acq_q;
	logic [7:0]        pre_q;
	logic [1:0]        tsel_q;
	logic [7:0]        count_q;
	logic [7:0]        count_d;
	logic [7:0]        target_q;
	logic [2:0]        shift_q;
	logic [15:0]       upper_q;
	logic [15:0]       lower_q;
	logic [15:0]       setpt_q;
	logic [11:0]       result_q;
	logic              computation_done_flag_q;
	logic [IRQ_W-1:0]  irq_st_q;
	logic [IRQ_W-1:0]  irq_st_d;
	logic [IRQ_W-1:0]  irq_msk_q;
	logic [31:0]       prdata_q;

	// Sequencer and trigger state.
	state_t     st_q;
	state_t     st_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       start_q;
	logic       start_d;
	logic       trig_prev_q;

	// Bus decode.
	logic wr_acc;
	logic rd_setup;
	logic hit;
	logic wr_ctrl;
	logic rd_clr;
	logic [31:0] rd_mux;

	// Control fields.
	logic       on;
	logic       auto;
	logic       dbl;
	comp_mode_t mode;

	// Sequencing terms.
	logic [7:0] phase_len;
	logic       phase_done;
	logic       in_conv;
	logic       conv_end;
	logic       finish;
	logic       launch;
	logic       trig_bit;
	logic       trig_set;
	logic [7:0] cnt_inc;
	logic       check;
	logic       restart;
	logic       relaunch;
	logic       start_set;
	logic       start_clr;

	// Computation interface.
	cmp_cfg_t cfg;
	cmp_res_t res;
	logic     upd;
	logic [IRQ_W-1:0] irq_ev;
	logic [7:0]       stage_flags;

	// Control fields decoded from the control register.
	assign on   = ctrl_q[CTRL_ON];
	assign auto = ctrl_q[CTRL_AUTO];
	assign dbl  = ctrl_q[CTRL_DOUBLE];
	assign mode = comp_mode_t'(ctrl_q[CTRL_MODE +: 2]);

	// APB strobes; every access completes in its first access cycle.
	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wr_ctrl  = wr_acc & (paddr == OFS_CTRL);
	assign rd_clr   = psel & penable & ~pwrite & (paddr == OFS_IRQ_ST);

	// Address decode for the mapped words.
	assign hit = (paddr == OFS_CTRL)    | (paddr == OFS_TIMING) |
		(paddr == OFS_TRIGSEL) | (paddr == OFS_STAGE)  |
		(paddr == OFS_COUNT)   | (paddr == OFS_TARGET) |
		(paddr == OFS_UPPER)   | (paddr == OFS_LOWER)  |
		(paddr == OFS_SETPT)   | (paddr == OFS_RESULT) |
		(paddr == OFS_FLT_HI)  | (paddr == OFS_FLT_LO) |
		(paddr == OFS_IRQ_ST)  | (paddr == OFS_IRQ_MSK);

	// Handshake outputs.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata  = prdata_q;

	// Stage flags: overflow, thresholds, computation, code.
	// The code follows the sequencer state directly.
	// Under a slow system clock with the RC clock the code may lag.
	assign stage_flags = {res.ovf, res.above, res.below, computation_done_flag_q,
		1'b0, stage_code(st_q)};

	// Read selection; filter bytes are read-only.
	assign rd_mux =
		(paddr == OFS_CTRL)    ? {25'h0, ctrl_q[CTRL_W-1:CTRL_START+1],
			start_q, ctrl_q[CTRL_ON]} :
		(paddr == OFS_TIMING)  ? {16'h0, pre_q, acq_q} :
		(paddr == OFS_TRIGSEL) ? {30'h0, tsel_q} :
		(paddr == OFS_STAGE)   ? {24'h0, stage_flags} :
		(paddr == OFS_COUNT)   ? {24'h0, count_q} :
		(paddr == OFS_TARGET)  ? {21'h0, shift_q, target_q} :
		(paddr == OFS_UPPER)   ? {16'h0, upper_q} :
		(paddr == OFS_LOWER)   ? {16'h0, lower_q} :
		(paddr == OFS_SETPT)   ? {16'h0, setpt_q} :
		(paddr == OFS_RESULT)  ? {20'h0, result_q} :
		(paddr == OFS_FLT_HI)  ? {24'h0, res.filter[15:8]} :
		(paddr == OFS_FLT_LO)  ? {24'h0, res.filter[7:0]} :
		(paddr == OFS_IRQ_ST)  ? {29'h0, irq_st_q} :
		(paddr == OFS_IRQ_MSK) ? {29'h0, irq_msk_q} :
		32'h0000_0000;

	// Read data is captured in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_q <= rd_mux;
		end
	end

	// Writable configuration registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= '0;
			acq_q     <= RST_BYTE;
			pre_q     <= RST_BYTE;
			tsel_q    <= 2'h0;
			target_q  <= RST_BYTE;
			shift_q   <= 3'h0;
			upper_q   <= 16'h0000;
			lower_q   <= 16'h0000;
			setpt_q   <= 16'h0000;
			irq_msk_q <= '0;
		end else if (wr_acc) begin
			unique case (paddr)
				OFS_CTRL: begin
					ctrl_q <= pwdata[CTRL_W-1:0];
				end
				OFS_TIMING: begin
					acq_q <= pwdata[7:0];
					pre_q <= pwdata[TIM_PRE +: 8];
				end
				OFS_TRIGSEL: begin
					tsel_q <= pwdata[1:0];
				end
				OFS_TARGET: begin
					target_q <= pwdata[7:0];
					shift_q  <= pwdata[TGT_SHIFT +: 3];
				end
				OFS_UPPER: begin
					upper_q <= pwdata[15:0];
				end
				OFS_LOWER: begin
					lower_q <= pwdata[15:0];
				end
				OFS_SETPT: begin
					setpt_q <= pwdata[15:0];
				end
				OFS_IRQ_MSK: begin
					irq_msk_q <= pwdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Trigger select and rising-edge detect.
	assign trig_bit = trig_in[tsel_q];
	assign trig_set = auto & on & trig_bit & ~trig_prev_q;

	// Start bit: set by software or trigger, cleared on completion unless a burst relaunches.
	// A set in the same cycle as a clear wins.
	assign start_set = (wr_ctrl & pwdata[CTRL_START]) | trig_set;
	assign start_clr = (finish & ~relaunch) |
		(wr_ctrl & ~pwdata[CTRL_START]) | ~on;
	assign start_d = start_set ? 1'b1 :
		(start_clr ? 1'b0 : start_q);

	// Length of the current phase in clock cycles.
	// A zero acquisition setting gives a one-cycle phase.
	assign phase_len =
		((st_q == ST_PRE1) | (st_q == ST_PRE2)) ? pre_q :
		((st_q == ST_ACQ1) | (st_q == ST_ACQ2)) ? acq_q :
		CONV_CYCLES;
	assign phase_done = ({1'b0, cnt_q} + 9'h001) >= {1'b0, phase_len};

	// Conversion ends and completion of the whole cycle.
	assign in_conv  = (st_q == ST_CONV1) | (st_q == ST_CONV2);
	assign conv_end = in_conv & phase_done & start_q;
	assign finish   = conv_end & ((st_q == ST_CONV2) | ~dbl);
	assign launch   = (st_q == ST_IDLE) & start_q & on;

	// Sequencer next state; a cleared start aborts to idle.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (launch) begin
					st_d = ST_PRE1;
				end
			end
			ST_PRE1: begin
				if (phase_done) begin
					st_d = ST_ACQ1;
				end
			end
			ST_ACQ1: begin
				if (phase_done) begin
					st_d = ST_CONV1;
				end
			end
			ST_CONV1: begin
				if (phase_done) begin
					st_d = dbl ? ST_PRE2 : ST_IDLE;
				end
			end
			ST_PRE2: begin
				if (phase_done) begin
					st_d = ST_ACQ2;
				end
			end
			ST_ACQ2: begin
				if (phase_done) begin
					st_d = ST_CONV2;
				end
			end
			ST_CONV2: begin
				if (phase_done) begin
					st_d = ST_IDLE;
				end
			end
		endcase
		if (!start_q) begin
			st_d = ST_IDLE;
		end
	end

	// Phase cycle counter restarts on every state change.
	assign cnt_d = (st_d != st_q) ? 8'h00 : 8'(cnt_q + 8'h01);

	// Analog control strobes follow the phase.
	assign precharge_en = (st_q == ST_PRE1) | (st_q == ST_PRE2);
	assign acquire_en   = (st_q == ST_ACQ1) | (st_q == ST_ACQ2);
	assign convert_en   = in_conv;
	assign converter_on = on;
	assign rc_clk_sel   = ctrl_q[CTRL_RCSEL];

	// Sequencer, start and trigger registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= ST_IDLE;
			cnt_q       <= 8'h00;
			start_q     <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			st_q        <= st_d;
			cnt_q       <= cnt_d;
			start_q     <= start_d;
			trig_prev_q <= trig_bit;
		end
	end

	// Repeat counting and threshold-check decision.
	assign cnt_inc  = 8'(count_q + 8'h01);
	assign check    = (mode == MODE_ACCUM) | (cnt_inc >= target_q);
	assign restart  = check &
		((mode == MODE_AVERAGE) | (mode == MODE_BURST));
	assign relaunch = (mode == MODE_BURST) & ~check;

	// Counter update: hardware counting wins over a software write.
	assign count_d = finish ? (restart ? 8'h00 : cnt_inc) :
		((wr_acc & (paddr == OFS_COUNT)) ? pwdata[7:0] : count_q);

	// Counter and conversion result registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q  <= RST_BYTE;
			result_q <= 12'h000;
		end else begin
			count_q <= count_d;
			if (conv_end) begin
				result_q <= conv_data;
			end
		end
	end

	// Settings for the computation unit.
	assign cfg.mode     = mode;
	assign cfg.shift    = shift_q;
	assign cfg.upper    = upper_q;
	assign cfg.lower    = lower_q;
	assign cfg.setpoint = setpt_q;

	// Accumulator, filter and threshold compare.
	compute_unit u_compute (
		.pclk       (pclk),
		.presetn    (presetn),
		.sample_stb (conv_end),
		.sample     (conv_data),
		.check      (finish & check),
		.restart    (finish & restart),
		.cfg        (cfg),
		.res        (res),
		.upd        (upd)
	);

	// Computation flag: set on update, cleared as a new cycle starts.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			computation_done_flag_q <= 1'b0;
		end else if (upd) begin
			computation_done_flag_q <= 1'b1;
		end else if (launch) begin
			computation_done_flag_q <= 1'b0;
		end
	end

	// Interrupt events: completion, threshold crossing, overflow.
	assign irq_ev[IRQ_DONE] = finish;
	assign irq_ev[IRQ_THR]  = upd & (res.above | res.below);
	assign irq_ev[IRQ_OVF]  = upd & res.ovf;

	// Sticky status; a read clears only the bits it returned.
	// An event in the clearing cycle is kept.
	assign irq_st_d = (irq_st_q &
		~(rd_clr ? prdata_q[IRQ_W-1:0] : '0)) | irq_ev;

	// Interrupt status register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_q <= '0;
		end else begin
			irq_st_q <= irq_st_d;
		end
	end

	// Level interrupt; wake does not depend on the global enable.
	assign irq        = |(irq_st_q & irq_msk_q);
	assign wake       = irq;
	assign irq_vector = irq & global_irq_enable;

endmodule

// ==== dv/adc_csu_sva.sv ====
// Purpose: Port-level checks of the converter status unit.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes:   An APB write may abort a phase, so phase checks exclude it.
module adc_csu_sva
	import adc_csu_pkg::*;
#(
	parameter logic [7:0] CONV_CYCLES = 8'h0E
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic global_irq_enable,
	input wire logic converter_on,
	input wire logic precharge_en,
	input wire logic acquire_en,
	input wire logic convert_en,
	input wire logic irq,
	input wire logic irq_vector,
	input wire logic wake
);
	logic [7:0] conv_len_q;
	logic       wr_acc;

	// A write access can legally cut a phase short.
	assign wr_acc = psel && penable && pwrite;

	// Counts how many cycles the conversion phase has lasted so far.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			conv_len_q <= 8'h00;
		else if (convert_en)
			conv_len_q <= conv_len_q + 8'h01;
		else
			conv_len_q <= 8'h00;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ready_access;
		psel && penable |-> pready;
	endproperty
	property p_err_access;
		pslverr |-> psel && penable;
	endproperty
	property p_phase_single;
		$onehot0({precharge_en, acquire_en, convert_en});
	endproperty
	property p_acq_after_pre;
		$rose(acquire_en) |-> $past(precharge_en);
	endproperty
	property p_conv_after_acq;
		$rose(convert_en) |-> $past(acquire_en);
	endproperty
	property p_pre_to_acq;
		$fell(precharge_en) && !$past(wr_acc, 2) |-> acquire_en;
	endproperty
	property p_conv_length;
		$fell(convert_en) && !$past(wr_acc, 2) |-> conv_len_q == CONV_CYCLES;
	endproperty
	property p_wake_irq;
		wake == irq;
	endproperty
	property p_vector_gate;
		irq_vector == (irq && global_irq_enable);
	endproperty
	property p_off_idle;
		$fell(converter_on) |=> !(precharge_en || acquire_en || convert_en);
	endproperty

	a_ready_access: assert property (p_ready_access)
		else $error("pready low in access cycle");
	a_err_access: assert property (p_err_access)
		else $error("pslverr outside access cycle");
	a_phase_single: assert property (p_phase_single)
		else $error("more than one phase enable high");
	a_acq_after_pre: assert property (p_acq_after_pre)
		else $error("acquisition not preceded by precharge");
	a_conv_after_acq: assert property (p_conv_after_acq)
		else $error("conversion not preceded by acquisition");
	a_pre_to_acq: assert property (p_pre_to_acq)
		else $error("precharge not followed by acquisition");
	a_conv_length: assert property (p_conv_length)
		else $error("conversion phase has wrong length");
	a_wake_irq: assert property (p_wake_irq)
		else $error("wake differs from irq");
	a_vector_gate: assert property (p_vector_gate)
		else $error("irq_vector not gated by global enable");
	a_off_idle: assert property (p_off_idle)
		else $error("phase still active after switch off");

	c_conv_end: cover property ($fell(convert_en));
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_double: cover property ($rose(precharge_en) && $past(convert_en));
endmodule

// ==== dv/test_adc_csu.sv ====
// Purpose: Register-level test of the converter status unit.
// Assumes: Zero-wait APB slave; conversion phases of default length.
// Notes:   Completion is found by polling the start bit.
module test_adc_csu
	import adc_csu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, err;
	logic        pslverr, pready, global_irq_enable, converter_on;
	logic        rc_clk_sel, precharge_en, acquire_en, convert_en;
	logic        irq, irq_vector, wake;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  trig_in;
	logic [11:0] conv_data;
	int          failures, samples_checked, cycles;

	adc_csu dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trig_in(trig_in), .conv_data(conv_data),
		.global_irq_enable(global_irq_enable),
		.converter_on(converter_on), .rc_clk_sel(rc_clk_sel),
		.precharge_en(precharge_en), .acquire_en(acquire_en),
		.convert_en(convert_en), .irq(irq), .irq_vector(irq_vector),
		.wake(wake));

	// Clock of 40 ns period.
	always #20 pclk = ~pclk;

	// Cuts a hung run short.
	always @(posedge pclk) begin
		cycles++;
		if (cycles > 20000) begin
			failures++;
			complete_run();
		end
	end

	task complete_run;
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task check(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, e, rd & m);
	endtask

	task wait_conv(input logic lvl);
		for (int i = 0; i < 60 && convert_en !== lvl; i++)
			@(negedge pclk);
	endtask

	// Starts a conversion and polls the start bit until it clears.
	task conv(input logic [31:0] ctrl, input logic dbl);
		apb(1'b1, OFS_CTRL, ctrl);
		rd_chk(OFS_CTRL, 32'h2, 32'h2, "start bit");
		wait_conv(1'b1);
		rd_chk(OFS_STAGE, 32'h7, 32'h3, "first stage");
		if (dbl) begin
			wait_conv(1'b0);
			wait_conv(1'b1);
			rd_chk(OFS_STAGE, 32'h7, 32'h7, "second stage");
		end
		rd = 32'hFFFFFFFF;
		for (int i = 0; i < 40 && rd[CTRL_START] !== 1'b0; i++)
			apb(1'b0, OFS_CTRL, 32'h0);
		@(negedge pclk);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		trig_in = 4'h0;
		conv_data = 12'hABC;
		global_irq_enable = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Reset value, read-only and unmapped words.
		rd_chk(OFS_STAGE, 32'hFF, 32'h00, "stage reset");
		apb(1'b1, OFS_STAGE, 32'hFF);
		rd_chk(OFS_STAGE, 32'hFF, 32'h00, "stage write");
		apb(1'b0, 8'h3C, 32'h0);
		check("unmapped err", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, rd);
		// One accumulate conversion with the done interrupt unmasked.
		apb(1'b1, OFS_TIMING, 32'h0101);
		apb(1'b1, OFS_TARGET, 32'h0001);
		apb(1'b1, OFS_UPPER, 32'h0100);
		apb(1'b1, OFS_IRQ_MSK, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h1);
		conv(32'h3, 1'b0);
		check("irq", 32'h1, {31'h0, irq});
		rd_chk(OFS_STAGE, 32'hFF, 32'h50, "flags");
		rd_chk(OFS_FLT_HI, 32'hFF, 32'h0A, "filter high");
		rd_chk(OFS_FLT_LO, 32'hFF, 32'hBC, "filter low");
		rd_chk(OFS_COUNT, 32'hFF, 32'h01, "count");
		rd_chk(OFS_IRQ_ST, 32'h1, 32'h1, "done set");
		rd_chk(OFS_IRQ_ST, 32'h7, 32'h0, "done clear");
		@(negedge pclk);
		check("irq clear", 32'h0, {31'h0, irq});
		apb(1'b1, OFS_FLT_LO, 32'h55);
		rd_chk(OFS_FLT_LO, 32'hFF, 32'hBC, "filter ro");
		// Second sample, shift of two, global enable off.
		conv_data <= 12'h100;
		global_irq_enable <= 1'b0;
		apb(1'b1, OFS_TARGET, 32'h0201);
		conv(32'h3, 1'b0);
		check("wake", 32'h1, {31'h0, wake});
		check("vector", 32'h0, {31'h0, irq_vector});
		rd_chk(OFS_FLT_HI, 32'hFF, 32'h02, "shift high");
		rd_chk(OFS_FLT_LO, 32'hFF, 32'hEF, "shift low");
		// Double cycle with the interrupt masked.
		apb(1'b1, OFS_IRQ_MSK, 32'h0);
		apb(1'b0, OFS_IRQ_ST, 32'h0);
		conv(32'h23, 1'b1);
		check("masked irq", 32'h0, {31'h0, irq});
		rd_chk(OFS_STAGE, 32'h7, 32'h0, "stage idle");
		rd_chk(OFS_COUNT, 32'hFF, 32'h03, "double count");
		rd_chk(OFS_IRQ_ST, 32'h1, 32'h1, "masked done");
		// Auto trigger: unselected source ignored, selected one starts.
		apb(1'b1, OFS_TRIGSEL, 32'h2);
		apb(1'b1, OFS_CTRL, 32'h5);
		trig_in <= 4'h2;
		wait_conv(1'b1);
		check("other source", 32'h0, {31'h0, convert_en});
		@(posedge pclk);
		trig_in <= 4'h4;
		wait_conv(1'b1);
		check("trigger", 32'h1, {31'h0, convert_en});
		wait_conv(1'b0);
		repeat (3) @(negedge pclk);
		rd_chk(OFS_IRQ_ST, 32'h1, 32'h1, "trigger done");
		// Clearing start mid-conversion aborts with no result.
		apb(1'b1, OFS_CTRL, 32'h3);
		wait_conv(1'b1);
		apb(1'b1, OFS_CTRL, 32'h1);
		// The sequencer reaches idle one cycle after start clears.
		repeat (2) @(negedge pclk);
		check("abort", 32'h0, {31'h0, convert_en});
		repeat (3) @(negedge pclk);
		rd_chk(OFS_IRQ_ST, 32'h1, 32'h0, "abort done");
		// Switching off mid-conversion with the RC clock selected.
		apb(1'b1, OFS_CTRL, 32'h43);
		wait_conv(1'b1);
		check("rc select", 32'h1, {31'h0, rc_clk_sel});
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (2) @(negedge pclk);
		check("off", 32'h0, {31'h0, converter_on});
		check("off abort", 32'h0, {31'h0, convert_en});
		// Low-pass with no shift follows the sample exactly.
		apb(1'b1, OFS_TARGET, 32'h0001);
		conv_data <= 12'h123;
		conv(32'h1B, 1'b0);
		rd_chk(OFS_FLT_HI, 32'hFF, 32'h01, "lpf high");
		rd_chk(OFS_FLT_LO, 32'hFF, 32'h23, "lpf low");
		// Average restarts the count; burst relaunches up to the target.
		conv(32'h0B, 1'b0);
		rd_chk(OFS_COUNT, 32'hFF, 32'h00, "average count");
		apb(1'b1, OFS_TARGET, 32'h0002);
		conv(32'h13, 1'b0);
		rd_chk(OFS_COUNT, 32'hFF, 32'h00, "burst count");
		rd_chk(OFS_FLT_LO, 32'hFF, 32'h46, "burst sum");
		complete_run();
	end
endmodule

bind adc_csu adc_csu_sva #(.CONV_CYCLES(CONV_CYCLES)) sva_u (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr),
	.global_irq_enable(global_irq_enable), .converter_on(converter_on),
	.precharge_en(precharge_en), .acquire_en(acquire_en),
	.convert_en(convert_en), .irq(irq), .irq_vector(irq_vector),
	.wake(wake));
